// >>> mci_pkg.sv
// Purpose: shared constants and types for the motion command interpreter
// Assumes: byte-wide host port mapped onto an 8-bit Avalon-MM slave
// Notes:   codes and field positions are used by the design and the bench
package mci_pkg;

  // avalon word addresses
  localparam logic [0:0] ADDR_CMD_STATUS = 1'h0; // write command, read status
  localparam logic [0:0] ADDR_DATA       = 1'h1; // data byte, high byte first

  // command codes
  localparam logic [7:0] CMD_INTERRUPT_MASK   = 8'h1C;
  localparam logic [7:0] CMD_RESET_INTERRUPTS = 8'h1D;
  localparam logic [7:0] CMD_LOAD_TRAJECTORY  = 8'h1F;
  localparam logic [7:0] CMD_SET_ABS_BKPT     = 8'h20;
  localparam logic [7:0] CMD_SET_REL_BKPT     = 8'h21;

  // status byte layout
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BKPT_BIT = 6;
  localparam int IRQ_LSB       = 1;
  localparam int IRQ_MSB       = 6;

  // trajectory control word fields
  localparam int TCW_FORWARD_BIT  = 12;
  localparam int TCW_VEL_MODE_BIT = 11;
  localparam int TCW_ACC_LOAD_BIT = 5;
  localparam int TCW_ACC_REL_BIT  = 4;
  localparam int TCW_VEL_LOAD_BIT = 3;
  localparam int TCW_VEL_REL_BIT  = 2;
  localparam int TCW_POS_LOAD_BIT = 1;
  localparam int TCW_POS_REL_BIT  = 0;

  // busy time after a command byte or a second data byte
  localparam int CLK_PERIOD_NS = 20;
  localparam int BUSY_TIME_NS  = 100;
  localparam int BUSY_CYCLES   = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reset values
  localparam logic [5:0]  MASK_RESET  = 6'h00;
  localparam logic [6:1]  FLAGS_RESET = 6'h00;
  localparam logic [15:0] TCW_RESET   = 16'h0000;
  localparam logic [31:0] PARAM_RESET = 32'h00000000;

  // loaded trajectory, handed to the trajectory generator
  typedef struct packed {
    logic [15:0] ctrl;
    logic [31:0] accel;
    logic [31:0] vel;
    logic [31:0] pos;
    logic        forward;
    logic        vel_mode;
  } mci_traj_t;

  // interpreter sequence states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MASK,
    ST_RSTI,
    ST_BKPT,
    ST_TCW,
    ST_PARAM
  } mci_state_t;

endpackage

// >>> mci_motion_cmd.sv
// Purpose: host command interpreter for mask, breakpoint and trajectory load
// Assumes: one 50 MHz clock, inputs synchronous, Avalon-MM 8-bit slave
// Notes:   address 0 = command write / status read, address 1 = data byte
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module mci_motion_cmd
  import mci_pkg::*;
#(
  parameter int BUSY_CNT = BUSY_CYCLES
)
(
  // clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_NRST,
  // avalon-mm slave
  input  wire logic [0:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [7:0]  I_AVS_WRITEDATA,
  output logic      [7:0]  O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  // motion state from the servo core
  input  wire logic [31:0] I_SHAFT_POS,
  input  wire logic [31:0] I_TARGET_POS,
  input  wire logic [5:1]  I_EVENT,
  // results
  output mci_traj_t        O_TRAJ,
  output logic             O_TRAJ_LOADED,
  output logic             O_HOST_INT
);

  // bus and port state
  logic        wait_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  busy_cnt_reg;
  logic        busy;
  logic        hi_pending_reg;
  logic [7:0]  hi_byte_reg;
  // interpreter state
  mci_state_t  state_reg;
  logic        half_reg;
  logic [15:0] high_word_reg;
  logic        is_rel_bp_reg;
  logic [2:0]  left_reg;
  // stored settings and flags
  logic [5:0]  mask_reg;
  logic [6:1]  flags_reg;
  logic [31:0] bp_pos_reg;
  logic        bp_armed_reg;
  mci_traj_t   traj_reg;
  logic        loaded_reg;
  logic        int_reg;

  // decoded strobes
  logic        accept;
  logic        cmd_wr;
  logic        dat_wr;
  logic        word_stb;
  logic [15:0] word;
  logic [31:0] long_word;
  logic [2:0]  cur_sel;
  logic [2:0]  left_next;
  logic        bp_hit;
  logic [6:1]  flags_next;
  logic [7:0]  status;

  // a transfer completes in the cycle waitrequest is low
  assign accept   = (I_AVS_READ | I_AVS_WRITE) & ~wait_reg;
  assign busy     = busy_cnt_reg != 8'h00;
  assign cmd_wr   = accept & I_AVS_WRITE & ~busy & (I_AVS_ADDRESS == ADDR_CMD_STATUS);
  assign dat_wr   = accept & I_AVS_WRITE & ~busy & (I_AVS_ADDRESS == ADDR_DATA);
  assign word_stb = dat_wr & hi_pending_reg;
  assign word     = {hi_byte_reg, I_AVS_WRITEDATA};
  assign long_word = {high_word_reg, word};
  assign status   = {1'b0, flags_reg, busy};

  // waitrequest low for one cycle per request, read data set with it
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      wait_reg  <= 1'b1;
      rdata_reg <= 8'h00;
    end
    else if (wait_reg && (I_AVS_READ || I_AVS_WRITE))
    begin
      wait_reg  <= 1'b0;
      rdata_reg <= (I_AVS_ADDRESS == ADDR_CMD_STATUS) ? status : 8'h00;
    end
    else
    begin
      wait_reg <= 1'b1;
    end
  end

  // busy time after a command byte or the second byte of a word
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      busy_cnt_reg <= 8'h00;
    end
    else if (cmd_wr || word_stb)
    begin
      busy_cnt_reg <= 8'(BUSY_CNT);
    end
    else if (busy)
    begin
      busy_cnt_reg <= busy_cnt_reg - 8'h01;
    end
  end

  // pair data bytes into words, high byte first
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      hi_pending_reg <= 1'b0;
      hi_byte_reg    <= 8'h00;
    end
    else if (cmd_wr)
    begin
      hi_pending_reg <= 1'b0;
    end
    else if (dat_wr)
    begin
      hi_pending_reg <= ~hi_pending_reg;
      if (!hi_pending_reg)
      begin
        hi_byte_reg <= I_AVS_WRITEDATA;
      end
    end
  end

  // pick the next trajectory parameter: accel, then velocity, then position
  always_comb
  begin
    cur_sel = 3'h0;
    if (left_reg[2])
    begin
      cur_sel = 3'h4;
    end
    else if (left_reg[1])
    begin
      cur_sel = 3'h2;
    end
    else if (left_reg[0])
    begin
      cur_sel = 3'h1;
    end
    left_next = left_reg & ~cur_sel;
  end

  // command sequencer
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      state_reg     <= ST_IDLE;
      half_reg      <= 1'b0;
      high_word_reg <= 16'h0000;
      is_rel_bp_reg <= 1'b0;
      left_reg      <= 3'h0;
    end
    else if (cmd_wr)
    begin
      half_reg <= 1'b0;
      case (I_AVS_WRITEDATA)
        CMD_INTERRUPT_MASK:   state_reg <= ST_MASK;
        CMD_RESET_INTERRUPTS: state_reg <= ST_RSTI;
        CMD_LOAD_TRAJECTORY:  state_reg <= ST_TCW;
        CMD_SET_ABS_BKPT:
        begin
          state_reg     <= ST_BKPT;
          is_rel_bp_reg <= 1'b0;
        end
        CMD_SET_REL_BKPT:
        begin
          state_reg     <= ST_BKPT;
          is_rel_bp_reg <= 1'b1;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
    else if (word_stb)
    begin
      case (state_reg)
        ST_MASK, ST_RSTI:
        begin
          state_reg <= ST_IDLE;
        end
        ST_BKPT:
        begin
          high_word_reg <= word;
          half_reg      <= ~half_reg;
          if (half_reg)
          begin
            state_reg <= ST_IDLE;
          end
        end
        ST_TCW:
        begin
          left_reg  <= {word[TCW_ACC_LOAD_BIT], word[TCW_VEL_LOAD_BIT], word[TCW_POS_LOAD_BIT]};
          state_reg <= (word[TCW_ACC_LOAD_BIT] || word[TCW_VEL_LOAD_BIT] || word[TCW_POS_LOAD_BIT])
                       ? ST_PARAM : ST_IDLE;
        end
        ST_PARAM:
        begin
          high_word_reg <= word;
          half_reg      <= ~half_reg;
          if (half_reg)
          begin
            left_reg <= left_next;
            if (left_next == 3'h0)
            begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // interrupt mask: high byte dropped, low byte bits one to six kept
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      mask_reg <= MASK_RESET;
    end
    else if (word_stb && state_reg == ST_MASK)
    begin
      mask_reg <= I_AVS_WRITEDATA[IRQ_MSB:IRQ_LSB];
    end
  end

  // breakpoint position, absolute or relative to the commanded target
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      bp_pos_reg   <= PARAM_RESET;
      bp_armed_reg <= 1'b0;
    end
    else if (word_stb && state_reg == ST_BKPT && half_reg)
    begin
      bp_armed_reg <= 1'b1;
      if (is_rel_bp_reg)
      begin
        bp_pos_reg <= I_TARGET_POS + long_word;
      end
      else
      begin
        bp_pos_reg <= long_word;
      end
    end
    else if (bp_hit)
    begin
      bp_armed_reg <= 1'b0;
    end
  end

  // breakpoint reached when the shaft lands on the stored position
  assign bp_hit = bp_armed_reg & (I_SHAFT_POS == bp_pos_reg);

  // sticky condition flags; a new event wins over a reset-interrupts clear
  always_comb
  begin
    flags_next = flags_reg;
    if (word_stb && state_reg == ST_RSTI)
    begin
      flags_next = flags_reg & I_AVS_WRITEDATA[IRQ_MSB:IRQ_LSB];
    end
    flags_next = flags_next | {bp_hit, I_EVENT};
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      flags_reg <= FLAGS_RESET;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  // host interrupt follows any enabled flag, mask not touching the flags
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      int_reg <= 1'b0;
    end
    else
    begin
      int_reg <= |(flags_reg & mask_reg);
    end
  end

  // trajectory control word and parameter loading
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      traj_reg.ctrl     <= TCW_RESET;
      traj_reg.accel    <= PARAM_RESET;
      traj_reg.vel      <= PARAM_RESET;
      traj_reg.pos      <= PARAM_RESET;
      traj_reg.forward  <= 1'b0;
      traj_reg.vel_mode <= 1'b0;
    end
    else if (word_stb && state_reg == ST_TCW)
    begin
      traj_reg.ctrl     <= word;
      traj_reg.forward  <= word[TCW_FORWARD_BIT];
      traj_reg.vel_mode <= word[TCW_VEL_MODE_BIT];
    end
    else if (word_stb && state_reg == ST_PARAM && half_reg)
    begin
      case (cur_sel)
        3'h4:
        begin
          traj_reg.accel <= traj_reg.ctrl[TCW_ACC_REL_BIT]
                            ? traj_reg.accel + long_word : long_word;
        end
        3'h2:
        begin
          traj_reg.vel <= traj_reg.ctrl[TCW_VEL_REL_BIT]
                          ? traj_reg.vel + long_word : long_word;
        end
        3'h1:
        begin
          traj_reg.pos <= traj_reg.ctrl[TCW_POS_REL_BIT]
                          ? I_TARGET_POS + long_word : long_word;
        end
        default:
        begin
          traj_reg.pos <= traj_reg.pos;
        end
      endcase
    end
  end

  // one-cycle pulse when the last selected parameter has arrived
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      loaded_reg <= 1'b0;
    end
    else
    begin
      loaded_reg <= word_stb & (state_reg == ST_PARAM) & half_reg & (left_next == 3'h0);
    end
  end

  // outputs straight from flip-flops
  assign O_AVS_READDATA    = rdata_reg;
  assign O_AVS_WAITREQUEST = wait_reg;
  assign O_TRAJ            = traj_reg;
  assign O_TRAJ_LOADED     = loaded_reg;
  assign O_HOST_INT        = int_reg;

endmodule

// >>> mci_motion_cmd_properties.sv
// Purpose: bus and output assertions for the command interpreter
// Assumes: one clock domain, reset active low
// Notes:   sees the top-level ports only
`timescale 1ns/10ps
module mci_motion_cmd_properties
  import mci_pkg::*;
(
  // clock and reset
  input  wire logic       I_CLOCK,
  input  wire logic       I_NRST,
  // avalon-mm
  input  wire logic [0:0] I_AVS_ADDRESS,
  input  wire logic       I_AVS_READ,
  input  wire logic       I_AVS_WRITE,
  input  wire logic [7:0] O_AVS_READDATA,
  input  wire logic       O_AVS_WAITREQUEST,
  // results
  input  wire mci_traj_t  O_TRAJ,
  input  wire logic       O_TRAJ_LOADED,
  input  wire logic       O_HOST_INT
);
  default clocking @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_NRST);
  // accepted read, accepted data write
  logic ack_rd;
  logic ack_wr;
  assign ack_rd = I_AVS_READ && !O_AVS_WAITREQUEST;
  assign ack_wr = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == 1'h1;
  // handshake shape
  a_wait_single: assert property ($fell(O_AVS_WAITREQUEST) |=> O_AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_wait_answer: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("request not answered");
  a_wait_idle: assert property (!I_AVS_READ && !I_AVS_WRITE |=> O_AVS_WAITREQUEST)
    else $error("answer without request");
  // read data contents
  a_read_zero: assert property (ack_rd && I_AVS_ADDRESS == 1'h1 |-> O_AVS_READDATA == 8'h00)
    else $error("data read not zero");
  a_status_top: assert property (ack_rd && I_AVS_ADDRESS == 1'h0 |-> !O_AVS_READDATA[7])
    else $error("status bit 7 set");
  // trajectory outputs
  a_traj_pulse: assert property (O_TRAJ_LOADED |=> !O_TRAJ_LOADED)
    else $error("load pulse too long");
  a_traj_mode: assert property (O_TRAJ_LOADED |-> O_TRAJ.forward == O_TRAJ.ctrl[TCW_FORWARD_BIT]
    && O_TRAJ.vel_mode == O_TRAJ.ctrl[TCW_VEL_MODE_BIT]) else $error("mode bits differ");
  // interrupt drops only after a data write
  a_int_fall: assert property ($fell(O_HOST_INT) |-> $past(ack_wr, 2) || $past(ack_wr, 3))
    else $error("host interrupt dropped alone");
endmodule
bind mci_motion_cmd mci_motion_cmd_properties chk_u (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST),
  .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_TRAJ(O_TRAJ),
  .O_TRAJ_LOADED(O_TRAJ_LOADED), .O_HOST_INT(O_HOST_INT));

// >>> mci_host_model.sv
// Purpose: host processor model on the byte-wide command port
// Assumes: avalon-mm master, one request at a time
// Notes:   the bench calls the tasks; released lines show inverted values
`timescale 1ns/10ps
module mci_host_model
  import mci_pkg::*;
(
  // clock
  input  wire logic       i_clk,
  // avalon-mm master
  output logic      [0:0] o_addr,
  output logic            o_rd,
  output logic            o_wr,
  output logic      [7:0] o_wdata,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_wait
);
  // idle bus at time zero
  initial
  begin
    o_addr = 1'h0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  // one transfer, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [0:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= !w;
    // no local limit: only the bench watchdog may end a hung wait
    do
    begin
      @(posedge i_clk);
    end
    while (i_wait !== 1'b0);
    q = i_rdata;
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // status read
  task automatic stat(output logic [7:0] q);
    xfer(1'b0, ADDR_CMD_STATUS, 8'h00, q);
  endtask
  // poll until busy clears
  task automatic idle;
    logic [7:0] q;
    do
    begin
      stat(q);
    end
    while (q[STAT_BUSY_BIT] !== 1'b0);
  endtask
  // command byte
  task automatic cmd(input logic [7:0] c);
    logic [7:0] q;
    xfer(1'b1, ADDR_CMD_STATUS, c, q);
    idle();
  endtask
  // data word, high byte first
  task automatic word(input logic [15:0] w);
    logic [7:0] q;
    xfer(1'b1, ADDR_DATA, w[15:8], q);
    xfer(1'b1, ADDR_DATA, w[7:0], q);
    idle();
  endtask
endmodule

// >>> motion_cmd_irq_breakpoint_tb.sv
// Purpose: self-checking bench for the command interpreter
// Assumes: busy count at its default, long enough to refuse a back-to-back byte
// Notes:   random values from a fixed seed, corner cases among them
`timescale 1ns/10ps
module motion_cmd_irq_breakpoint_tb;
  import mci_pkg::*;
  // bench signals
  logic        clk;
  logic        nrst;
  logic [0:0]  addr;
  logic        rd;
  logic        wr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        waitr;
  logic [31:0] shaft;
  logic [31:0] target;
  logic [5:1]  ev;
  mci_traj_t   traj;
  logic        loaded;
  logic        hint;
  int          seed;
  int          bad_count;
  int          comparisons;
  int          n_loaded;
  int          i;
  logic [7:0]  q;
  logic [7:0]  m;
  logic [5:1]  e;
  logic [31:0] v;
  logic [31:0] d;
  logic [31:0] acc;
  // design and host
  mci_motion_cmd #(.BUSY_CNT(BUSY_CYCLES)) dut_u (.I_CLOCK(clk), .I_NRST(nrst), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(waitr), .I_SHAFT_POS(shaft), .I_TARGET_POS(target), .I_EVENT(ev),
    .O_TRAJ(traj), .O_TRAJ_LOADED(loaded), .O_HOST_INT(hint));
  mci_host_model host_u (.i_clk(clk), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata),
    .i_rdata(rdata), .i_wait(waitr));
  // clock and load pulse count
  always #10 clk = ~clk;
  always @(posedge clk)
    if (loaded === 1'b1)
      n_loaded++;
  // compare and count
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected host interrupt
  function automatic logic exp_int(input logic [7:0] mk, input logic [5:1] ev_in);
    return |(mk[5:1] & ev_in);
  endfunction
  // mask word with a random high byte
  task automatic set_mask(input logic [7:0] mk);
    host_u.cmd(CMD_INTERRUPT_MASK);
    host_u.word({8'($random(seed)), mk});
  endtask
  // 32-bit value as two words
  task automatic put32(input logic [31:0] x);
    host_u.word(x[31:16]);
    host_u.word(x[15:0]);
  endtask
  // shaft position, then settle
  task automatic put_pos(input logic [31:0] x);
    @(posedge clk);
    shaft <= x;
    repeat (4) @(posedge clk);
  endtask
  // clear all flags and confirm
  task automatic clr;
    host_u.cmd(CMD_RESET_INTERRUPTS);
    host_u.word({8'($random(seed)), 8'h00});
    repeat (4) @(posedge clk);
    host_u.stat(q);
    check_eq(q, 8'h00);
    check_eq(hint, 1'b0);
  endtask
  // verdict
  task automatic report_and_stop;
    $display("counts: %0d compares, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    shaft = 32'h00000000;
    target = 32'h00000000;
    ev = 5'h00;
    seed = 19252;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    host_u.stat(q);
    check_eq(q, 8'h00);
    // data port reads back zero
    host_u.xfer(1'b0, ADDR_DATA, 8'h00, q);
    check_eq(q, 8'h00);
    // masks against raw events, first mask only the breakpoint
    for (i = 0; i < 5; i++)
    begin
      m = (i == 0) ? 8'h40 : 8'($random(seed));
      e = 5'($random(seed));
      set_mask(m);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 5'h00;
      repeat (4) @(posedge clk);
      host_u.stat(q);
      check_eq(q, {2'b00, e, 1'b0});
      check_eq(hint, exp_int(m, e));
      clr();
    end
    $display("test mask done");
    // absolute breakpoint, flag held after the shaft moves on
    // mask only the breakpoint; a data byte written while busy must be dropped
    host_u.xfer(1'b1, ADDR_CMD_STATUS, CMD_INTERRUPT_MASK, q);
    host_u.xfer(1'b1, ADDR_DATA, 8'h7E, q);
    host_u.idle();
    host_u.word(16'h0040);
    v = $random(seed);
    host_u.cmd(CMD_SET_ABS_BKPT);
    put32(v);
    put_pos(v);
    put_pos(~v);
    host_u.stat(q);
    check_eq(q, 8'h40);
    check_eq(hint, 1'b1);
    clr();
    $display("test absolute breakpoint done");
    // relative breakpoint adds the target position
    target <= $random(seed) | 32'h1;
    d = $random(seed);
    host_u.cmd(CMD_SET_REL_BKPT);
    put32(d);
    put_pos(d);
    host_u.stat(q);
    check_eq(q, 8'h00);
    put_pos(target + d);
    host_u.stat(q);
    check_eq(q, 8'h40);
    check_eq(hint, 1'b1);
    clr();
    $display("test relative breakpoint done");
    // trajectory, absolute accel and velocity
    v = $random(seed);
    d = $random(seed);
    host_u.cmd(CMD_LOAD_TRAJECTORY);
    host_u.word(16'h1828);
    put32(v);
    put32(d);
    repeat (4) @(posedge clk);
    check_eq(n_loaded, 1);
    check_eq(traj.ctrl, 16'h1828);
    check_eq(traj.accel, v);
    acc = v;
    check_eq(traj.vel, d);
    check_eq({traj.forward, traj.vel_mode}, 2'b11);
    // relative velocity only
    v = $random(seed);
    host_u.cmd(CMD_LOAD_TRAJECTORY);
    host_u.word(16'h180C);
    put32(v);
    repeat (4) @(posedge clk);
    check_eq(n_loaded, 2);
    check_eq(traj.vel, d + v);
    check_eq({traj.forward, traj.vel_mode}, 2'b11);
    // relative accel and relative position, no velocity word expected
    d = $random(seed);
    v = $random(seed);
    host_u.cmd(CMD_LOAD_TRAJECTORY);
    host_u.word(16'h0033);
    put32(d);
    put32(v);
    repeat (4) @(posedge clk);
    check_eq(n_loaded, 3);
    check_eq(traj.accel, acc + d);
    check_eq(traj.pos, target + v);
    check_eq({traj.forward, traj.vel_mode}, 2'b00);
    $display("test trajectory done");
    report_and_stop();
  end
endmodule
